// ===== src/ccu_consts.svh
// Purpose: offsets, field positions, reset values of the capture/compare unit
// Assumes: word index on the bus, byte address is four times the index
// Notes: definitions only
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH

`define CCU_IDX_FLAGS        10'h00C
`define CCU_IDX_VALUE_LOW    10'h013
`define CCU_IDX_VALUE_HIGH   10'h014
`define CCU_IDX_CONTROL      10'h015
`define CCU_IDX_ENABLES      10'h08C

`define CCU_EVENT_BIT        5
`define CCU_DUTY_MSB         5
`define CCU_DUTY_LSB         4
`define CCU_MODE_MSB         3
`define CCU_MODE_LSB         0

`define CCU_CONTROL_RESET    6'h00
`define CCU_FLAGS_RESET      1'b0
`define CCU_ENABLES_RESET    1'b0
`define CCU_VALUE_LOW_RESET  8'h00
`define CCU_VALUE_HIGH_RESET 8'h00
`define CCU_DUTY_RESET       10'h000

`define CCU_MODE_OFF         4'h0
`define CCU_MODE_TOGGLE      4'h2
`define CCU_MODE_CAP_FALL    4'h4
`define CCU_MODE_CAP_RISE    4'h5
`define CCU_MODE_CAP_4       4'h6
`define CCU_MODE_CAP_16      4'h7
`define CCU_MODE_SET_HIGH    4'h8
`define CCU_MODE_SET_LOW     4'h9
`define CCU_MODE_SOFT_EVENT  4'hA
`define CCU_MODE_SPECIAL     4'hB

`define CCU_PRESCALE_4_LAST  4'h3
`define CCU_PRESCALE_16_LAST 4'hF

`endif

// ===== src/ccu_pkg.sv
// Purpose: types shared by the capture/compare unit
// Assumes: constants come from ccu_consts.svh
// Notes: none
package ccu_pkg;

    typedef enum logic [2:0] {
        CCU_CLS_OFF,
        CCU_CLS_RESERVED,
        CCU_CLS_CAPTURE,
        CCU_CLS_COMPARE,
        CCU_CLS_PWM
    } ccu_class_e;

    typedef struct packed {
        logic [1:0] duty_low_bits;
        logic [3:0] unit_mode_select;
    } ccu_ctrl_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  idx;
        logic        sel0;
        logic [7:0]  dat;
    } ccu_wb_req_s;

endpackage : ccu_pkg

// ===== src/ccu_top.sv
// Purpose: capture/compare unit with a classic Wishbone register slave
// Assumes: timer one count and its clock tick arrive synchronous to clk_i
// Notes: pulse-width timing belongs to timer two and is not built here
`include "ccu_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// - value register as two byte registers
// - control bits seven and six read zero
// - control bits five, four hold duty low bits
// - mode 0000 turns unit off, resets state
// - 0100 falling, 0101 rising edge capture
// - 0110 fourth, 0111 sixteenth rising capture
// - 0010 toggles pin on match, sets flag
// - 1000 drives high, 1001 low, sets flag
// - 1010 sets flag only on match
// - 1011 sets flag, clears timer, starts converter
// - trigger clears timer, starts converter, not overflow
// - 110x active-high, 111x active-low pulse width
// - capture copies timer count into value
// - capture sets sticky event flag bit five
// - new capture overwrites value, no overrun
// - capture watches pin level, even when driven
// - prescaler cleared when off, non-capture, reset
// - prescaler switch keeps counter, may flag early
// - compare match sets flag, pin follows a cycle later
// - control zero forces output latch low
// - timer clear waits for next timer tick
module ccu_top
    import ccu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] timer_one_count_i,
    input  wire logic        timer_one_tick_i,
    input  wire logic        converter_enabled_i,
    input  wire logic        unit_pin_i,
    output logic             unit_pin_o,
    output logic             timer_one_clear_o,
    output logic             converter_start_o,
    output logic             unit_event_flag_o,
    output logic             unit_event_enable_o,
    output logic [9:0]       pwm_duty_o
);

    ccu_wb_req_s req;
    ccu_ctrl_s   ctrl_reg;
    logic [7:0]  value_low_reg;
    logic [7:0]  value_high_reg;
    logic        flag_reg;
    logic        enable_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        pin_prev_reg;
    logic [3:0]  presc_reg;
    logic        match_prev_reg;
    logic        latch_reg;
    logic        pending_reg;
    logic        clear_reg;
    logic        start_reg;
    logic        pin_out_reg;
    logic        wr_en;
    logic        wr_ctrl;
    logic        ctrl_off_next;
    ccu_class_e  cls;
    logic        rise;
    logic        fall;
    logic        cap_event;
    logic        match_now;
    logic        match_hit;
    logic [3:0]  mode;
    logic        req_live;
    logic        wr_flags;
    logic        wr_enables;
    logic        wr_low;
    logic        wr_high;
    logic        is_capture;
    logic        is_compare;
    logic        is_special;
    logic        flag_set;
    logic [15:0] value_word;
    logic [9:0]  duty_reg;

    function automatic ccu_class_e mode_class(input logic [3:0] m);
        ccu_class_e c;
        c = CCU_CLS_RESERVED;
        if (m == `CCU_MODE_OFF) begin
            c = CCU_CLS_OFF;
        end else if (m[3:2] == 2'b01) begin
            c = CCU_CLS_CAPTURE;
        end else if (m == `CCU_MODE_TOGGLE || m[3:2] == 2'b10) begin
            c = CCU_CLS_COMPARE;
        end else if (m[3:2] == 2'b11) begin
            c = CCU_CLS_PWM;
        end
        return c;
    endfunction : mode_class

    // one decode for every byte write, so no target skips the ack gate
    function automatic logic idx_write(input ccu_wb_req_s r,
                                       input logic        en,
                                       input logic [9:0]  i);
        return en && r.idx == i;
    endfunction : idx_write

    // only the low byte lane carries data; upper lanes are ignored
    assign req = '{cyc:  wb_cyc_i,
                   stb:  wb_stb_i,
                   we:   wb_we_i,
                   idx:  wb_adr_i[11:2],
                   sel0: wb_sel_i[0],
                   dat:  wb_dat_i[7:0]};

    // writes land on the edge where the master sees ack
    assign req_live   = req.cyc & req.stb;
    assign wr_en      = req_live & req.we & req.sel0 & ack_reg;
    assign wr_ctrl    = idx_write(req, wr_en, `CCU_IDX_CONTROL);
    assign wr_flags   = idx_write(req, wr_en, `CCU_IDX_FLAGS);
    assign wr_enables = idx_write(req, wr_en, `CCU_IDX_ENABLES);
    assign wr_low     = idx_write(req, wr_en, `CCU_IDX_VALUE_LOW);
    assign wr_high    = idx_write(req, wr_en, `CCU_IDX_VALUE_HIGH);

    // a zero write acts on its own edge, not a cycle later
    assign ctrl_off_next = wr_ctrl
        && req.dat[`CCU_MODE_MSB:`CCU_MODE_LSB] == `CCU_MODE_OFF;

    assign mode = ctrl_reg.unit_mode_select;
    assign cls  = mode_class(mode);

    // class flags shared by capture, compare and trigger logic
    assign is_capture = (cls == CCU_CLS_CAPTURE);
    assign is_compare = (cls == CCU_CLS_COMPARE);
    assign is_special = (mode == `CCU_MODE_SPECIAL);

    // pin level sampled directly so a driven port still triggers
    assign rise = unit_pin_i & ~pin_prev_reg;
    assign fall = ~unit_pin_i & pin_prev_reg;

    always_comb begin
        cap_event = 1'b0;
        if (cls == CCU_CLS_CAPTURE) begin
            unique case (mode)
                `CCU_MODE_CAP_FALL: cap_event = fall;
                `CCU_MODE_CAP_RISE: cap_event = rise;
                `CCU_MODE_CAP_4:
                    cap_event = rise
                        && presc_reg[1:0] == `CCU_PRESCALE_4_LAST;
                default:
                    cap_event = rise
                        && presc_reg == `CCU_PRESCALE_16_LAST;
            endcase
        end
    end

    // acting on the first equal cycle keeps a held count from retoggling
    assign value_word = {value_high_reg, value_low_reg};
    assign match_now  = value_word == timer_one_count_i;
    assign match_hit  = is_compare & match_now & ~match_prev_reg;

    // any hardware event that raises the sticky flag
    assign flag_set   = cap_event | match_hit;

    // bus answer: ack one edge after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req_live & ~ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= 32'h0000_0000;
            unique case (req.idx)
                `CCU_IDX_FLAGS:
                    rdata_reg[`CCU_EVENT_BIT] <= flag_reg;
                `CCU_IDX_ENABLES:
                    rdata_reg[`CCU_EVENT_BIT] <= enable_reg;
                `CCU_IDX_VALUE_LOW:  rdata_reg[7:0] <= value_low_reg;
                `CCU_IDX_VALUE_HIGH: rdata_reg[7:0] <= value_high_reg;
                `CCU_IDX_CONTROL:
                    rdata_reg[5:0] <= ctrl_reg;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `CCU_CONTROL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= req.dat[5:0];
        end
    end

    // a capture in the same cycle as a byte write wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_low_reg <= `CCU_VALUE_LOW_RESET;
        end else if (cap_event) begin
            value_low_reg <= timer_one_count_i[7:0];
        end else if (wr_low) begin
            value_low_reg <= req.dat;
        end
    end

    // bytes are not latched as a pair: software sees each write at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_high_reg <= `CCU_VALUE_HIGH_RESET;
        end else if (cap_event) begin
            value_high_reg <= timer_one_count_i[15:8];
        end else if (wr_high) begin
            value_high_reg <= req.dat;
        end
    end

    // set beats a software clear landing on the same edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= `CCU_FLAGS_RESET;
        end else begin
            if (wr_flags) begin
                flag_reg <= req.dat[`CCU_EVENT_BIT] | flag_set;
            end else if (flag_set) begin
                flag_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg <= `CCU_ENABLES_RESET;
        end else if (wr_enables) begin
            enable_reg <= req.dat[`CCU_EVENT_BIT];
        end
    end

    // reset level matches the idle low pin, so no false edge follows reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= unit_pin_i;
        end
    end

    // equality must drop before a compare can fire again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_prev_reg <= 1'b0;
        end else begin
            match_prev_reg <= match_now & is_compare;
        end
    end

    // prescale switches keep the count, so the first capture may be early
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_reg <= 4'h0;
        end else if (!is_capture || ctrl_off_next) begin
            presc_reg <= 4'h0;
        end else if (rise) begin
            presc_reg <= presc_reg + 4'h1;
        end
    end

    // compare output latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_reg <= 1'b0;
        end else if (ctrl_off_next || cls == CCU_CLS_OFF) begin
            latch_reg <= 1'b0;
        end else if (match_hit) begin
            unique case (mode)
                `CCU_MODE_TOGGLE:   latch_reg <= ~latch_reg;
                `CCU_MODE_SET_HIGH: latch_reg <= 1'b1;
                `CCU_MODE_SET_LOW:  latch_reg <= 1'b0;
                default:            latch_reg <= latch_reg;
            endcase
        end
    end

    // pin shows the latch; pulse-width modes rest at their idle level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_reg <= 1'b0;
        end else if (cls == CCU_CLS_PWM) begin
            pin_out_reg <= mode[1];
        end else begin
            pin_out_reg <= latch_reg;
        end
    end

    // special trigger: clear waits for the timer's next tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_reg <= 1'b0;
        end else if (ctrl_off_next || !is_special) begin
            pending_reg <= 1'b0;
        end else if (pending_reg && !match_now) begin
            pending_reg <= 1'b0;
        end else if (pending_reg && timer_one_tick_i) begin
            pending_reg <= 1'b0;
        end else if (match_hit) begin
            pending_reg <= 1'b1;
        end
    end

    // moving the value off the count before the tick cancels the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_reg <= 1'b0;
        end else begin
            clear_reg <= pending_reg && match_now && timer_one_tick_i
                         && is_special && !ctrl_off_next;
        end
    end

    // start is a one-cycle strobe; the converter holds its own busy bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= match_hit && is_special
                         && converter_enabled_i;
        end
    end

    // registered so the duty port comes from a flop like every output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_reg <= `CCU_DUTY_RESET;
        end else begin
            duty_reg <= {value_low_reg, ctrl_reg.duty_low_bits};
        end
    end

    assign wb_ack_o            = ack_reg;
    assign wb_dat_o            = rdata_reg;
    assign unit_pin_o          = pin_out_reg;
    assign timer_one_clear_o   = clear_reg;
    assign converter_start_o   = start_reg;
    assign unit_event_flag_o   = flag_reg;
    assign unit_event_enable_o = enable_reg;
    assign pwm_duty_o          = duty_reg;

endmodule : ccu_top

`default_nettype wire

// ===== test/ccu_top_assertions.sv
// Purpose: port checks for the capture/compare unit
// Assumes: one-cycle Wishbone ack, pulses one cycle wide
// Notes: bound to ccu_top at the foot of this file
`include "ccu_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ccu_top_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        timer_one_tick_i,
    input wire logic        converter_enabled_i,
    input wire logic        timer_one_clear_o,
    input wire logic        converter_start_o,
    input wire logic        unit_event_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // software clear is the only way down for the sticky flag
    logic flag_wr;
    assign flag_wr = wb_ack_o && wb_we_i && wb_adr_i[11:2] == `CCU_IDX_FLAGS;
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_ctrl_top_zero: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i[11:2] == `CCU_IDX_CONTROL |-> wb_dat_o[31:6] == 26'h0)
        else $error("control top bits set");
    a_flag_sticky: assert property ($fell(unit_event_flag_o) |->
        $past(flag_wr)) else $error("flag lost");
    a_start_cause: assert property (converter_start_o |->
        $past(converter_enabled_i) && unit_event_flag_o)
        else $error("start without cause");
    a_start_once: assert property (converter_start_o |=> !converter_start_o)
        else $error("start too long");
    a_clear_tick: assert property (timer_one_clear_o |->
        $past(timer_one_tick_i)) else $error("clear off tick");
    a_clear_once: assert property (timer_one_clear_o |=> !timer_one_clear_o)
        else $error("clear too long");
endmodule : ccu_top_assertions
bind ccu_top ccu_top_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_one_tick_i(timer_one_tick_i),
    .converter_enabled_i(converter_enabled_i),
    .timer_one_clear_o(timer_one_clear_o),
    .converter_start_o(converter_start_o),
    .unit_event_flag_o(unit_event_flag_o));
`default_nettype wire

// ===== test/capture_compare_unit_tb.sv
// Purpose: self-checking bench for the capture/compare unit
// Assumes: capture lands one edge after a pin change
// Notes: waits of four cycles cover the stated latencies
`include "ccu_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module capture_compare_unit_tb;
    logic        clk_i, rst_i, req, we, tick, cen, pin;
    logic        ack, pin_o, clr, start, flag, en_o;
    logic [11:0] adr;
    logic [31:0] dat, rdat, rd_o;
    logic [15:0] cnt;
    logic [9:0]  duty;
    int          err_count, comparisons, nclr, nstart;
    logic [7:0]  modes [6] = '{8'h02, 8'h09, 8'h08, 8'h0A, 8'h03, 8'h01};
    logic        pexp [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    ccu_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rd_o), .wb_ack_o(ack),
        .timer_one_count_i(cnt), .timer_one_tick_i(tick),
        .converter_enabled_i(cen), .unit_pin_i(pin), .unit_pin_o(pin_o),
        .timer_one_clear_o(clr), .converter_start_o(start),
        .unit_event_flag_o(flag), .unit_event_enable_o(en_o),
        .pwm_duty_o(duty));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (clr === 1'b1) nclr++;
        if (start === 1'b1) nstart++;
    end
    task automatic wrap_up();
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) err_count++;
        rdat = rd_o;
        req <= 1'b0;
    endtask : bus
    task automatic rd_chk(input logic [9:0] i, input logic [31:0] exp);
        bus(1'b0, i, 8'h00);
        chk(rdat, exp);
    endtask : rd_chk
    task automatic pulses(input int k);
        repeat (k) begin
            @(posedge clk_i) pin <= 1'b1;
            repeat (3) @(posedge clk_i);
            pin <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask : pulses
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end
    initial begin
        {req, we, tick, cen, pin, adr, dat, cnt} = '0;
        rst_i = 1'b1;
        {err_count, comparisons, nclr, nstart} = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`CCU_IDX_FLAGS, 32'h0);
        rd_chk(`CCU_IDX_ENABLES, 32'h0);
        rd_chk(`CCU_IDX_CONTROL, 32'h0);
        bus(1'b1, `CCU_IDX_CONTROL, 8'hFF);
        bus(1'b1, `CCU_IDX_VALUE_LOW, 8'hA5);
        rd_chk(`CCU_IDX_CONTROL, 32'h3F);
        chk(duty, {8'hA5, 2'b11});
        chk(pin_o, 1'b1);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h2C);
        repeat (2) @(posedge clk_i);
        chk(duty, {8'hA5, 2'b10});
        chk(pin_o, 1'b0);
        bus(1'b1, `CCU_IDX_ENABLES, 8'hFF);
        rd_chk(`CCU_IDX_ENABLES, 32'h20);
        chk(en_o, 1'b1);
        rd_chk(10'h3FF, 32'h0);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h05);
        cnt <= 16'hBEEF;
        pulses(1);
        rd_chk(`CCU_IDX_VALUE_LOW, 32'hEF);
        rd_chk(`CCU_IDX_VALUE_HIGH, 32'hBE);
        rd_chk(`CCU_IDX_FLAGS, 32'h20);
        cnt <= 16'h1357;
        pulses(1);
        rd_chk(`CCU_IDX_VALUE_LOW, 32'h57);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h04);
        @(posedge clk_i) pin <= 1'b1;
        repeat (3) @(posedge clk_i);
        cnt <= 16'h2222;
        pin <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd_chk(`CCU_IDX_VALUE_LOW, 32'h22);
        // off between counts must throw the partial count away
        bus(1'b1, `CCU_IDX_CONTROL, 8'h06);
        pulses(2);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h00);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h06);
        bus(1'b1, `CCU_IDX_FLAGS, 8'h00);
        cnt <= 16'h0C0D;
        pulses(3);
        rd_chk(`CCU_IDX_FLAGS, 32'h0);
        pulses(1);
        rd_chk(`CCU_IDX_VALUE_LOW, 32'h0D);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h00);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h06);
        pulses(2);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h07);
        bus(1'b1, `CCU_IDX_FLAGS, 8'h00);
        pulses(13);
        rd_chk(`CCU_IDX_FLAGS, 32'h0);
        pulses(1);
        rd_chk(`CCU_IDX_FLAGS, 32'h20);
        cnt <= 16'h0000;
        bus(1'b1, `CCU_IDX_VALUE_LOW, 8'h34);
        bus(1'b1, `CCU_IDX_VALUE_HIGH, 8'h12);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, `CCU_IDX_CONTROL, modes[i]);
            bus(1'b1, `CCU_IDX_FLAGS, 8'h00);
            cnt <= 16'h1234;
            repeat (4) @(posedge clk_i);
            chk(pin_o, pexp[i]);
            rd_chk(`CCU_IDX_FLAGS, i < 4 ? 32'h20 : 32'h0);
            cnt <= 16'h0000;
        end
        bus(1'b1, `CCU_IDX_CONTROL, 8'h00);
        repeat (2) @(posedge clk_i);
        chk(pin_o, 1'b0);
        bus(1'b1, `CCU_IDX_CONTROL, 8'h0B);
        // second pass drops the match before the tick, so no clear
        for (int i = 0; i < 2; i++) begin
            cen <= (i == 0);
            bus(1'b1, `CCU_IDX_FLAGS, 8'h00);
            cnt <= 16'h1234;
            repeat (3) @(posedge clk_i);
            if (i == 1) cnt <= 16'h0000;
            @(posedge clk_i) tick <= 1'b1;
            @(posedge clk_i) tick <= 1'b0;
            repeat (3) @(posedge clk_i);
            cnt <= 16'h0000;
            rd_chk(`CCU_IDX_FLAGS, 32'h20);
        end
        chk(nclr, 1);
        chk(nstart, 1);
        chk(pin_o, 1'b0);
        wrap_up();
    end
endmodule : capture_compare_unit_tb
`default_nettype wire
